// ---- bit_shift_flag_exec_defines.vh ----
// Shared constants of the bit, shift and flag execution unit
`ifndef BIT_SHIFT_FLAG_EXEC_DEFINES_VH
`define BIT_SHIFT_FLAG_EXEC_DEFINES_VH

// Operation codes on instr_op
`define OP_NOP        5'h00
`define OP_BR_OVF_CLR 5'h01
`define OP_BR_IRQ_EN  5'h02
`define OP_BR_IRQ_DIS 5'h03
`define OP_IO_SET     5'h04
`define OP_IO_CLR     5'h05
`define OP_SHIFT_LEFT  5'h06
`define OP_SHIFT_RIGHT 5'h07
`define OP_ROT_LEFT    5'h08
`define OP_ROT_RIGHT   5'h09
`define OP_SHIFT_ARITH 5'h0a
`define OP_BIT_TO_T   5'h0b
`define OP_T_TO_BIT   5'h0c
`define OP_SET_C      5'h0d
`define OP_CLR_C      5'h0e
`define OP_SET_N      5'h0f
`define OP_CLR_N      5'h10
`define OP_SET_Z      5'h11
`define OP_CLR_Z      5'h12
`define OP_SET_S      5'h13

// Status register bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// APB byte offsets
`define ADDR_CTRL   12'h000
`define ADDR_STATUS 12'h004
`define ADDR_PC     12'h008
`define ADDR_INFO   12'h00c
`define ADDR_GPR    12'h100
`define ADDR_IO     12'h200

// Reset values
`define CTRL_RST   1'b1
`define STATUS_RST 8'h00
`define PC_RST     16'h0000

`endif

// ---- shift_rotate_unit.v ----
// Shift and rotate datapath with its flag results
`timescale 1ns/1ns
`default_nettype none
`include "bit_shift_flag_exec_defines.vh"

module shift_rotate_unit (
  input  wire [4:0] op,
  input  wire [7:0] din,
  input  wire       cin,
  output reg  [7:0] dout,
  output reg        c_out,
  output wire       z_out,
  output wire       n_out,
  output wire       v_out
);

  // Result and carry per shift kind
  always @* begin
    case (op)
      `OP_SHIFT_LEFT: begin
        dout  = {din[6:0], 1'b0};
        c_out = din[7];
      end
      `OP_SHIFT_RIGHT: begin
        dout  = {1'b0, din[7:1]};
        c_out = din[0];
      end
      `OP_ROT_LEFT: begin
        dout  = {din[6:0], cin};
        c_out = din[7];
      end
      `OP_ROT_RIGHT: begin
        dout  = {cin, din[7:1]};
        c_out = din[0];
      end
      `OP_SHIFT_ARITH: begin
        dout  = {din[7], din[7:1]};
        c_out = din[0];
      end
      default: begin
        dout  = din;
        c_out = cin;
      end
    endcase
  end

  // Z and N derived from the result; V from result bit 7 and the carry out
  assign z_out = (dout == 8'h00);
  assign n_out = dout[7];
  assign v_out = dout[7] ^ c_out;

endmodule // shift_rotate_unit
`default_nettype wire

// ---- branch_target_unit.v ----
// Branch condition test and target address
`timescale 1ns/1ns
`default_nettype none
`include "bit_shift_flag_exec_defines.vh"

module branch_target_unit #(
  parameter PC_W = 16
) (
  input  wire [4:0]      op,
  input  wire            flag_v,
  input  wire            flag_i,
  input  wire [PC_W-1:0] pc,
  input  wire [6:0]      offset,
  output reg             taken,
  output wire [PC_W-1:0] target
);

  wire [PC_W-1:0] offs_ext;

  // Sign-extend the 7-bit word offset
  assign offs_ext = {{(PC_W-7){offset[6]}}, offset};

  // Target wraps around the program space
  assign target = pc + offs_ext + {{(PC_W-1){1'b0}}, 1'b1};

  // Condition per branch kind
  always @* begin
    case (op)
      `OP_BR_OVF_CLR: taken = ~flag_v;
      `OP_BR_IRQ_EN:  taken = flag_i;
      `OP_BR_IRQ_DIS: taken = ~flag_i;
      default:        taken = 1'b0;
    endcase
  end

endmodule // branch_target_unit
`default_nettype wire

// ---- bit_shift_flag_exec_unit.v ----
// Execution unit top: sequencing, register file, I/O space and APB slave
`timescale 1ns/1ns
`default_nettype none
`include "bit_shift_flag_exec_defines.vh"

module bit_shift_flag_exec_unit #(
  parameter PC_W  = 16,
  parameter GPR_N = 32,
  parameter IO_N  = 64
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire             instr_valid,
  output wire             instr_ready,
  input  wire [4:0]       instr_op,
  input  wire [4:0]       instr_reg,
  input  wire [2:0]       instr_bit,
  input  wire [5:0]       instr_io,
  input  wire [6:0]       instr_offset,
  output reg              op_done,
  output wire [PC_W-1:0]  pc_out,
  output wire [7:0]       status_out
);

  localparam ST_IDLE = 2'd0;
  localparam ST_BR2  = 2'd1;
  localparam ST_IO2  = 2'd2;

  reg  [1:0]      state_ff;
  reg  [1:0]      nxt_state;
  reg  [PC_W-1:0] pc_ff;
  reg  [PC_W-1:0] nxt_pc;
  reg  [7:0]      status_ff;
  reg  [7:0]      nxt_status;
  reg             run_ff;
  reg  [4:0]      op_ff;
  reg  [2:0]      bit_ff;
  reg  [5:0]      io_addr_ff;
  reg  [7:0]      io_val_ff;
  reg  [PC_W-1:0] tgt_ff;
  reg  [7:0]      gpr_mem [0:GPR_N-1];
  reg  [7:0]      io_mem  [0:IO_N-1];
  reg             gpr_we;
  reg  [7:0]      gpr_wdata;
  reg             io_we;
  reg  [7:0]      io_wdata;
  reg             nxt_done;
  wire            accept;
  wire [7:0]      rd_val;
  wire [7:0]      sh_res;
  wire            sh_c;
  wire            sh_z;
  wire            sh_n;
  wire            sh_v;
  wire            br_taken;
  wire [PC_W-1:0] br_target;
  wire [PC_W-1:0] pc_inc;
  wire            apb_wr;
  wire            apb_setup;
  wire            hit_gpr;
  wire            hit_io;
  wire            hit_reg;
  wire [4:0]      apb_gidx;
  wire [5:0]      apb_iidx;
  reg  [31:0]     rd_mux;
  integer         i;
  integer         m;

  // One-hot mask of a bit index
  function [7:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = 8'h01 << b;
    end
  endfunction

  // Outputs straight from the state flops
  assign pc_out     = pc_ff;
  assign status_out = status_ff;
  assign pc_inc     = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
  assign rd_val     = gpr_mem[instr_reg];

  // New work only when idle and software lets the unit run
  assign instr_ready = run_ff && (state_ff == ST_IDLE);
  assign accept      = instr_valid && instr_ready;

  shift_rotate_unit u_shift (
    .op    (instr_op),
    .din   (rd_val),
    .cin   (status_ff[`FLAG_C]),
    .dout  (sh_res),
    .c_out (sh_c),
    .z_out (sh_z),
    .n_out (sh_n),
    .v_out (sh_v)
  );

  branch_target_unit #(
    .PC_W (PC_W)
  ) u_branch (
    .op     (instr_op),
    .flag_v (status_ff[`FLAG_V]),
    .flag_i (status_ff[`FLAG_I]),
    .pc     (pc_ff),
    .offset (instr_offset),
    .taken  (br_taken),
    .target (br_target)
  );

  // Sequencing and result selection
  always @* begin
    // Hold state by default; every write strobe stays low
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_status = status_ff;
    gpr_we    = 1'b0;
    gpr_wdata = 8'h00;
    io_we     = 1'b0;
    io_wdata  = 8'h00;
    nxt_done  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_pc   = pc_inc;
          nxt_done = 1'b1;
          case (instr_op)
            `OP_BR_OVF_CLR, `OP_BR_IRQ_EN, `OP_BR_IRQ_DIS: begin
              // Taken branches spend a second cycle; flags stay as they are
              if (br_taken) begin
                nxt_pc    = pc_ff;
                nxt_done  = 1'b0;
                nxt_state = ST_BR2;
              end else begin
                // Not taken: retire now at the next word
                nxt_pc   = pc_inc;
                nxt_done = 1'b1;
              end
            end
            `OP_IO_SET, `OP_IO_CLR: begin
              // Read now, write back in the second cycle
              nxt_pc    = pc_ff;
              nxt_done  = 1'b0;
              nxt_state = ST_IO2;
            end
            `OP_SHIFT_LEFT, `OP_SHIFT_RIGHT, `OP_ROT_LEFT, `OP_ROT_RIGHT,
            `OP_SHIFT_ARITH: begin
              gpr_we   = 1'b1;
              gpr_wdata = sh_res;
              nxt_status[`FLAG_C] = sh_c;
              nxt_status[`FLAG_Z] = sh_z;
              nxt_status[`FLAG_N] = sh_n;
              nxt_status[`FLAG_V] = sh_v;
            end
            `OP_BIT_TO_T: begin
              nxt_status[`FLAG_T] = rd_val[instr_bit];
            end
            `OP_T_TO_BIT: begin
              gpr_we = 1'b1;
              gpr_wdata = status_ff[`FLAG_T] ? (rd_val | bit_mask(instr_bit))
                                             : (rd_val & ~bit_mask(instr_bit));
            end
            `OP_SET_C: nxt_status[`FLAG_C] = 1'b1;
            `OP_CLR_C: nxt_status[`FLAG_C] = 1'b0;
            `OP_SET_N: nxt_status[`FLAG_N] = 1'b1;
            `OP_CLR_N: nxt_status[`FLAG_N] = 1'b0;
            `OP_SET_Z: nxt_status[`FLAG_Z] = 1'b1;
            `OP_CLR_Z: nxt_status[`FLAG_Z] = 1'b0;
            `OP_SET_S: nxt_status[`FLAG_S] = 1'b1;
            // Unknown codes retire as a one-cycle no-op
            default: nxt_pc = pc_inc;
          endcase
        end
      end
      // Second cycle of a taken branch
      ST_BR2: begin
        nxt_pc    = tgt_ff;
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      // Write back the modified byte and step on
      ST_IO2: begin
        io_we = 1'b1;
        if (op_ff == `OP_IO_SET) begin
          io_wdata = io_val_ff | bit_mask(bit_ff);
        end else begin
          io_wdata = io_val_ff & ~bit_mask(bit_ff);
        end
        nxt_pc    = pc_inc;
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // APB decode: one aligned word per register
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_gidx  = paddr[6:2];
  assign apb_iidx  = paddr[7:2];
  // Window compare at full address width so no bits are dropped
  assign hit_gpr   = ({7'h00, paddr[11:7]} == (`ADDR_GPR >> 7)) && (paddr[1:0] == 2'b00)
                     && ({27'h0, apb_gidx} < GPR_N);
  assign hit_io    = ({8'h00, paddr[11:8]} == (`ADDR_IO >> 8)) && (paddr[1:0] == 2'b00)
                     && ({26'h0, apb_iidx} < IO_N);
  assign hit_reg   = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS)
                     || (paddr == `ADDR_PC) || (paddr == `ADDR_INFO);

  // Zero-wait slave; an unmapped address is flagged, never stalled
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !(hit_gpr || hit_io || hit_reg);

  // Read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_gpr) begin
      rd_mux = {24'h00_0000, gpr_mem[apb_gidx]};
    end else if (hit_io) begin
      rd_mux = {24'h00_0000, io_mem[apb_iidx]};
    end else begin
      case (paddr)
        `ADDR_CTRL:   rd_mux = {31'h0, run_ff};
        `ADDR_STATUS: rd_mux = {24'h00_0000, status_ff};
        `ADDR_PC:     rd_mux = {{(32-PC_W){1'b0}}, pc_ff};
        `ADDR_INFO:   rd_mux = {30'h0, state_ff};
        default:      rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data captured in the setup cycle, held through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Core state; execution wins over a software write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      pc_ff    <= `PC_RST;
      status_ff <= `STATUS_RST;
      run_ff   <= `CTRL_RST;
      op_done  <= 1'b0;
    end else begin
      if (apb_wr && paddr == `ADDR_CTRL) begin
        run_ff <= pwdata[0];
      end
      if (apb_wr && paddr == `ADDR_STATUS) begin
        status_ff <= pwdata[7:0];
      end
      // PC load refused while an op is in flight, so a target is never lost
      if (apb_wr && paddr == `ADDR_PC && state_ff == ST_IDLE) begin
        pc_ff <= pwdata[PC_W-1:0];
      end
      if (accept || state_ff != ST_IDLE) begin
        pc_ff     <= nxt_pc;
        status_ff <= nxt_status;
      end
      state_ff <= nxt_state;
      op_done  <= nxt_done;
    end
  end

  // Operands kept for the second cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff      <= `OP_NOP;
      bit_ff     <= 3'd0;
      io_addr_ff <= 6'd0;
      io_val_ff  <= 8'h00;
      tgt_ff     <= {PC_W{1'b0}};
    end else if (accept) begin
      op_ff      <= instr_op;
      bit_ff     <= instr_bit;
      io_addr_ff <= instr_io;
      io_val_ff  <= io_mem[instr_io];
      tgt_ff     <= br_target;
    end
  end

  // Working registers: software port, then execution write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < GPR_N; i = i + 1) begin
        gpr_mem[i] <= 8'h00;
      end
    end else begin
      if (apb_wr && hit_gpr) begin
        gpr_mem[apb_gidx] <= pwdata[7:0];
      end
      if (gpr_we) begin
        gpr_mem[instr_reg] <= gpr_wdata;
      end
    end
  end

  // I/O space: only the chosen bit differs on write-back
  // A software write to the byte between read and write-back is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (m = 0; m < IO_N; m = m + 1) begin
        io_mem[m] <= 8'h00;
      end
    end else begin
      if (apb_wr && hit_io) begin
        io_mem[apb_iidx] <= pwdata[7:0];
      end
      if (io_we) begin
        io_mem[io_addr_ff] <= io_wdata;
      end
    end
  end

endmodule // bit_shift_flag_exec_unit
`default_nettype wire

// ---- bit_shift_flag_exec_chk.sv ----
// Concurrent checks on the ports of the bit, shift and flag execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bit_shift_flag_exec_defines.vh"

module bit_shift_flag_exec_chk #(
  parameter PC_W = 16
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            instr_valid,
  input wire logic            instr_ready,
  input wire logic [4:0]      instr_op,
  input wire logic [6:0]      instr_offset,
  input wire logic            op_done,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0]      status_out
);
  // Taken instruction and its branch target, from pc at take time
  wire            tk  = instr_valid & instr_ready;
  wire [PC_W-1:0] tgt = pc_out + {{(PC_W-7){instr_offset[6]}}, instr_offset} + 1'b1;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Taken branches retire after two cycles at the target
  a_vclr_jump: assert property (tk && instr_op == `OP_BR_OVF_CLR && !status_out[3] |=>
    !op_done ##1 op_done && pc_out == $past(tgt, 2)) else $error("overflow branch wrong");
  a_irq_dis_jump: assert property (tk && instr_op == `OP_BR_IRQ_DIS && !status_out[7] |=>
    !op_done ##1 op_done && pc_out == $past(tgt, 2)) else $error("irq off branch wrong");
  // Untaken branch steps once and keeps every flag
  a_irq_en_skip: assert property (tk && instr_op == `OP_BR_IRQ_EN && !status_out[7] |=>
    op_done && pc_out == $past(pc_out) + 1'b1 && $stable(status_out)) else $error("skip wrong");
  a_io_set_time: assert property (tk && instr_op == `OP_IO_SET |=>
    !op_done ##1 op_done && status_out == $past(status_out, 2)) else $error("io set wrong");
  a_io_clr_flags: assert property (tk && instr_op == `OP_IO_CLR |=>
    $stable(status_out) ##1 $stable(status_out)) else $error("io clear touched flags");
  // Shifts keep S, H, T, I and tie V to N and C
  a_irq_en_jump: assert property (tk && instr_op == `OP_BR_IRQ_EN && status_out[7] |=>
    !op_done ##1 op_done && pc_out == $past(tgt, 2) && status_out == $past(status_out, 2))
    else $error("irq on branch wrong");
  a_io_busy: assert property (tk && instr_op inside {`OP_IO_SET, `OP_IO_CLR} |=>
    !instr_ready) else $error("ready during second cycle");
  a_shift_ovf: assert property (tk && instr_op inside {[`OP_SHIFT_LEFT:`OP_SHIFT_ARITH]} |=>
    op_done &&
    status_out[3] == (status_out[2] ^ status_out[0]) && status_out[7:4] == $past(status_out[7:4]))
    else $error("shift flags wrong");
  a_bst_only_t: assert property (tk && instr_op == `OP_BIT_TO_T |=> op_done &&
    {status_out[7], status_out[5:0]} == $past({status_out[7], status_out[5:0]}))
    else $error("bit store touched flags");
  a_bld_keeps: assert property (tk && instr_op == `OP_T_TO_BIT |=>
    op_done && $stable(status_out)) else $error("bit load touched flags");
  a_set_carry: assert property (tk && instr_op == `OP_SET_C |=>
    status_out == ($past(status_out) | 8'h01)) else $error("carry set wrong");
  a_clr_zero: assert property (tk && instr_op == `OP_CLR_Z |=>
    status_out == ($past(status_out) & 8'hfd)) else $error("zero clear wrong");
  a_set_signed: assert property (tk && instr_op == `OP_SET_S |=>
    status_out == ($past(status_out) | 8'h10)) else $error("signed set wrong");
endmodule // bit_shift_flag_exec_chk

bind bit_shift_flag_exec_unit bit_shift_flag_exec_chk #(.PC_W(PC_W)) chk_i (
  .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr_op(instr_op), .instr_offset(instr_offset), .op_done(op_done), .pc_out(pc_out),
  .status_out(status_out));
`default_nettype wire

// ---- test_bit_shift_flag_exec_unit.sv ----
// Self-checking testbench of the bit, shift and flag execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bit_shift_flag_exec_defines.vh"

module test_bit_shift_flag_exec_unit;
  logic        pclk, presetn, psel, penable, pwrite, instr_valid, err, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [4:0]  instr_op, instr_reg, op;
  logic [2:0]  instr_bit;
  logic [5:0]  instr_io;
  logic [6:0]  instr_offset, k;
  logic [7:0]  d, s;
  logic [15:0] e;
  wire  [31:0] prdata;
  wire         pready, pslverr, instr_ready, op_done;
  wire  [15:0] pc_out;
  wire  [7:0]  status_out;
  int          n_mismatch = 0, compares = 0, lat, j, p;

  bit_shift_flag_exec_unit bit_shift_flag_exec_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op),
    .instr_reg(instr_reg), .instr_bit(instr_bit), .instr_io(instr_io),
    .instr_offset(instr_offset), .op_done(op_done), .pc_out(pc_out), .status_out(status_out));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Compare and count; case equality so unknowns never match
  task chk(input logic [15:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offer one instruction and count edges until it retires
  task exec(input logic [4:0] o, r, input logic [2:0] b, input logic [5:0] io,
            input logic [6:0] ko);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_reg <= r;
    instr_bit <= b;
    instr_io <= io;
    instr_offset <= ko;
    @(posedge pclk);
    instr_valid <= 1'b0;
    lat = 1;
    #1;
    while (op_done !== 1'b1 && lat < 8) begin
      @(posedge pclk);
      #1;
      lat++;
    end
  endtask

  // Expected shift result in the upper byte, status in the lower
  function automatic logic [15:0] shx(input logic [4:0] o, input logic [7:0] dv, sv);
    logic [7:0] r;
    logic       c;
    case (o)
      `OP_SHIFT_LEFT: {c, r} = {dv, 1'b0};
      `OP_SHIFT_RIGHT: {r, c} = {1'b0, dv};
      `OP_ROT_LEFT: {c, r} = {dv, sv[0]};
      `OP_ROT_RIGHT: {r, c} = {sv[0], dv};
      default: {r, c} = {dv[7], dv};
    endcase
    return {r, sv[7:4], r[7] ^ c, r[7], r == 8'h00, c};
  endfunction

  task end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Generous bound; the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, instr_valid, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {instr_op, instr_reg, instr_bit, instr_io, instr_offset} = 26'h000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd[15:0], 16'h0001, "ctrl reset");
    // Run bit low stops new work; state reads idle again after restart
    apb(1'b1, `ADDR_CTRL, 32'h0);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk({instr_ready, rd[14:0]}, 16'h0000, "stopped");
    apb(1'b1, `ADDR_CTRL, 32'h1);
    apb(1'b0, `ADDR_INFO, 32'h0);
    chk({instr_ready, rd[14:0]}, 16'h8000, "restarted idle");
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[14:0]}, 16'h8000, "unmapped read");
    chk(pc_out, `PC_RST, "pc reset");
    $display("test registers done");
    // Two passes: carry in set, then carry in clear with a result of zero from the three right shifts
    for (int i = 0; i < 10; i++) begin
      op = 5'(`OP_SHIFT_LEFT + i % 5);
      d = i < 5 ? 8'h81 : 8'h01;
      s = i < 5 ? 8'hf1 : 8'h70;
      apb(1'b1, `ADDR_GPR + 12'h004, {24'h0, d});
      apb(1'b1, `ADDR_STATUS, {24'h0, s});
      exec(op, 5'h01, 3'h0, 6'h00, 7'h00);
      e = shx(op, d, s);
      chk({lat[7:0], status_out}, {8'h01, e[7:0]}, "shift flags");
      apb(1'b0, `ADDR_GPR + 12'h004, 32'h0);
      chk(rd[15:0], {8'h00, e[15:8]}, "shift result");
    end
    $display("test shifts done");
    // Start from the opposite level so other bits are seen to stay
    for (int i = 0; i < 7; i++) begin
      p = i == 6 ? 4 : (i < 2 ? 0 : (i < 4 ? 2 : 1));
      t = !i[0];
      s = t ? 8'h00 : 8'hff;
      apb(1'b1, `ADDR_STATUS, {24'h0, s});
      exec(5'(`OP_SET_C + i), 5'h00, 3'h0, 6'h00, 7'h00);
      e = {8'h01, s};
      e[p] = t;
      chk({lat[7:0], status_out}, e, "flag op");
    end
    $display("test flags done");
    apb(1'b1, `ADDR_GPR + 12'h008, 32'h0000_0040);
    apb(1'b1, `ADDR_GPR + 12'h00c, 32'h0000_0000);
    apb(1'b1, `ADDR_STATUS, 32'h0000_00bf);
    exec(`OP_BIT_TO_T, 5'h02, 3'h6, 6'h00, 7'h00);
    chk({lat[7:0], status_out}, 16'h01ff, "bit store one");
    exec(`OP_T_TO_BIT, 5'h03, 3'h3, 6'h00, 7'h00);
    chk(lat[15:0], 16'h0001, "bit load cycles");
    apb(1'b0, `ADDR_GPR + 12'h00c, 32'h0);
    chk({rd[7:0], status_out}, 16'h08ff, "bit load");
    exec(`OP_BIT_TO_T, 5'h02, 3'h0, 6'h00, 7'h00);
    chk({lat[7:0], status_out}, 16'h01bf, "bit store zero");
    $display("test bit transfer done");
    apb(1'b1, `ADDR_IO + 12'h014, 32'h0000_005a);
    apb(1'b1, `ADDR_STATUS, 32'h0000_003c);
    exec(`OP_IO_SET, 5'h00, 3'h0, 6'h05, 7'h00);
    chk({lat[7:0], status_out}, 16'h023c, "io set");
    exec(`OP_IO_CLR, 5'h00, 3'h6, 6'h05, 7'h00);
    chk({lat[7:0], status_out}, 16'h023c, "io clear");
    apb(1'b0, `ADDR_IO + 12'h014, 32'h0);
    chk(rd[15:0], 16'h001b, "io byte");
    $display("test io bits done");
    // Each branch taken at an offset extreme, then not taken
    for (int i = 0; i < 6; i++) begin
      t = !i[0];
      j = i / 2;
      k = i[1] ? 7'h3f : 7'h40;
      s = j == 0 ? (t ? 8'h00 : 8'h08) : (((j == 1) == t) ? 8'h80 : 8'h00);
      apb(1'b1, `ADDR_PC, 32'h0000_0100);
      apb(1'b1, `ADDR_STATUS, {24'h0, s});
      exec(5'(`OP_BR_OVF_CLR + j), 5'h00, 3'h0, 6'h00, k);
      e = t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
      chk(pc_out, e, "branch target");
      chk({lat[7:0], status_out}, {t ? 8'h02 : 8'h01, s}, "branch cycles");
    end
    // Unknown code retires in one cycle and steps the counter
    exec(`OP_NOP, 5'h00, 3'h0, 6'h00, 7'h00);
    chk({lat[7:0], pc_out[7:0]}, 16'h0102, "no-op");
    $display("test branches done");
    end_sim();
  end
endmodule // test_bit_shift_flag_exec_unit
`default_nettype wire
